// ---- analog_input_diag_record.v ----
// Diagnostic record, microsecond timer and diagnostic interrupt events of a two-channel analog input.
`timescale 1ns/1ps
`include "diag_record_map.vh"
module analog_input_diag_record (
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  diag_interrupt_enable,
  input  wire        cause_module_fail,
  input  wire        cause_internal,
  input  wire        cause_external,
  input  wire        cause_aux_supply,
  input  wire        cause_param,
  input  wire        cause_buf_overflow,
  input  wire        cause_comm,
  input  wire [1:0]  cause_config,
  input  wire [1:0]  cause_pirq_lost,
  input  wire [1:0]  cause_underflow,
  input  wire [1:0]  cause_overflow,
  input  wire        process_event,
  input  wire        req_valid,
  input  wire [1:0]  req_kind,
  input  wire [7:0]  record_number,
  input  wire [15:0] object_index,
  input  wire [7:0]  object_subindex,
  input  wire [4:0]  req_byte,
  output reg         rsp_valid,
  output reg  [7:0]  rsp_data,
  output reg         rsp_error,
  output reg         rsp_last,
  output reg         diag_incoming,
  output reg         diag_going,
  output reg         module_fault_led,
  output reg  [15:0] process_irq_timestamp_low,
  output reg  [31:0] us_timer
);
  // Request kinds: record number, object index, per-byte object subindex.
  localparam [1:0] KIND_RECORD = 2'd0;
  localparam [1:0] KIND_INDEX  = 2'd1;
  localparam [1:0] KIND_SUBIDX = 2'd2;

  // Diagnostic event states.
  localparam [1:0] ST_IDLE   = 2'd0;
  localparam [1:0] ST_LATCH  = 2'd1;
  localparam [1:0] ST_ACTIVE = 2'd2;

  localparam [6:0] TICK_LAST = 7'd99;

  reg  [6:0]  tick_cnt_r;
  reg  [1:0]  state_r;
  reg  [2:0]  step_r;
  reg  [31:0] stamp_r;
  reg  [7:0]  merr_r;
  reg  [7:0]  ierr_r;
  reg  [7:0]  ch0_r;
  reg  [7:0]  ch1_r;
  reg         pend_r;
  reg  [4:0]  pend_byte_r;
  reg         pend_err_r;
  reg         pend_last_r;
  reg         wr_en;
  reg  [2:0]  wr_addr;
  reg  [7:0]  wr_data;
  wire [7:0]  store_q;
  wire [7:0]  live_merr;
  wire [7:0]  live_ierr;
  wire [7:0]  live_ch0;
  wire [7:0]  live_ch1;
  wire        cause_any;
  wire        diag_on;

  // Live cause bytes; reserved positions tie to zero.
  assign live_ch0 = {cause_overflow[0], cause_underflow[0], cause_pirq_lost[0], 4'h0,
                     cause_config[0]};
  assign live_ch1 = {cause_overflow[1], cause_underflow[1], cause_pirq_lost[1], 4'h0,
                     cause_config[1]};
  assign live_merr = {cause_param, 2'b00, cause_aux_supply, (|live_ch0) | (|live_ch1),
                      cause_external, cause_internal, cause_module_fail};
  assign live_ierr = {1'b0, cause_pirq_lost[0] | cause_pirq_lost[1], 1'b0, cause_comm,
                      cause_buf_overflow, 3'b000};
  assign cause_any = (|live_merr) | (|live_ierr);
  assign diag_on   = (diag_interrupt_enable == `DIAG_ENABLE_ON);

  // Microsecond tick divider and free-running 32-bit timer.
  always @(posedge clock) begin
    if (rst) begin
      tick_cnt_r <= 7'd0;
      us_timer   <= 32'h00000000;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= 7'd0;
      us_timer   <= us_timer + 32'h00000001;
    end else begin
      tick_cnt_r <= tick_cnt_r + 7'd1;
    end
  end

  // Process interrupt stamp keeps only the low half of the timer.
  always @(posedge clock) begin
    if (rst) begin
      process_irq_timestamp_low <= 16'h0000;
    end else if (process_event) begin
      process_irq_timestamp_low <= us_timer[15:0];
    end
  end

  // Event machine: capture on incoming, ignore changes until the cause clears.
  always @(posedge clock) begin
    if (rst) begin
      state_r          <= ST_IDLE;
      step_r           <= 3'd0;
      stamp_r          <= 32'h00000000;
      merr_r           <= 8'h00;
      ierr_r           <= 8'h00;
      ch0_r            <= 8'h00;
      ch1_r            <= 8'h00;
      diag_incoming    <= 1'b0;
      diag_going       <= 1'b0;
      module_fault_led <= 1'b0;
    end else begin
      diag_incoming <= 1'b0;
      diag_going    <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (cause_any && diag_on) begin
            stamp_r          <= us_timer;
            merr_r           <= live_merr;
            ierr_r           <= live_ierr;
            ch0_r            <= live_ch0;
            ch1_r            <= live_ch1;
            step_r           <= 3'd0;
            state_r          <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          // Copy the snapshot into the store one byte per cycle, then announce it.
          step_r <= step_r + 3'd1;
          if (step_r == 3'd7) begin
            state_r          <= ST_ACTIVE;
            diag_incoming    <= 1'b1;
            module_fault_led <= 1'b1;
          end
        end
        ST_ACTIVE: begin
          // Later cause changes are not recorded until the going event.
          if (!cause_any) begin
            state_r          <= ST_IDLE;
            diag_going       <= 1'b1;
            module_fault_led <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Store write map for the captured bytes.
  always @* begin
    wr_en   = (state_r == ST_LATCH);
    wr_addr = step_r;
    case (step_r)
      3'd0:    wr_data = merr_r;
      3'd1:    wr_data = ierr_r;
      3'd2:    wr_data = {6'h00, |ch1_r, |ch0_r};
      3'd3:    wr_data = ch0_r;
      3'd4:    wr_data = ch1_r;
      3'd5:    wr_data = stamp_r[7:0];
      3'd6:    wr_data = stamp_r[15:8];
      default: wr_data = stamp_r[23:16];
    endcase
  end

  // Decode request into record byte and access length.
  reg  [4:0] sel_byte;
  reg        sel_err;
  reg  [4:0] sel_len;
  reg  [2:0] rd_addr;
  wire [7:0] sub_offset;

  // Subindex to byte offset; only the low five bits are kept, range errors are caught below.
  assign sub_offset = object_subindex - `SUBIDX_FIRST_BYTE;

  always @* begin
    sel_byte = req_byte;
    sel_err  = 1'b0;
    sel_len  = `RECORD_LEN_FULL;
    case (req_kind)
      KIND_RECORD: begin
        if (record_number == `RECNUM_SHORT) begin
          sel_len = `RECORD_LEN_SHORT;
        end else if (record_number != `RECNUM_FULL) begin
          sel_err = 1'b1;
        end
      end
      KIND_INDEX: begin
        if (object_index == `OBJIDX_SHORT) begin
          sel_len = `RECORD_LEN_SHORT;
        end else if (object_index != `OBJIDX_FULL) begin
          sel_err = 1'b1;
        end
      end
      KIND_SUBIDX: begin
        sel_byte = sub_offset[4:0];
        sel_err  = (object_index != `OBJIDX_DIAG_BYTES) || (object_subindex < `SUBIDX_FIRST_BYTE) ||
                   (object_subindex >= (`SUBIDX_FIRST_BYTE + 8'd20));
      end
      default: begin
        sel_err = 1'b1;
      end
    endcase
    if (sel_byte >= sel_len) begin
      sel_err = 1'b1;
    end
    case (sel_byte)
      `BYTE_MODULE_ERR:   rd_addr = 3'd0;
      `BYTE_INTERNAL_ERR: rd_addr = 3'd1;
      `BYTE_GROUP_ERR:    rd_addr = 3'd2;
      `BYTE_CH0_ERR:      rd_addr = 3'd3;
      `BYTE_CH1_ERR:      rd_addr = 3'd4;
      5'd16:              rd_addr = 3'd5;
      5'd17:              rd_addr = 3'd6;
      default:            rd_addr = 3'd7;
    endcase
  end

  record_store u_store (
    .clock   (clock),
    .rst     (rst),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (store_q)
  );

  // First stage holds the request while the store read settles.
  always @(posedge clock) begin
    if (rst) begin
      pend_r      <= 1'b0;
      pend_byte_r <= 5'd0;
      pend_err_r  <= 1'b0;
      pend_last_r <= 1'b0;
    end else begin
      pend_r      <= req_valid;
      pend_byte_r <= sel_byte;
      pend_err_r  <= sel_err;
      pend_last_r <= (sel_byte == sel_len - 5'd1) || (req_kind == KIND_SUBIDX);
    end
  end

  // Answer stage: constants, stored bytes, top timestamp byte or zero.
  always @(posedge clock) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_error <= 1'b0;
      rsp_last  <= 1'b0;
    end else begin
      rsp_valid <= pend_r;
      rsp_error <= pend_r & pend_err_r;
      rsp_last  <= pend_r & pend_last_r;
      if (!pend_r || pend_err_r) begin
        rsp_data <= 8'h00;
      end else begin
        case (pend_byte_r)
          `BYTE_MODULE_ERR:   rsp_data <= store_q;
          `BYTE_MODULE_CLASS: rsp_data <= `MODULE_CLASS_VALUE;
          `BYTE_INTERNAL_ERR: rsp_data <= store_q;
          `BYTE_CHAN_KIND:    rsp_data <= `CHAN_KIND_VALUE;
          `BYTE_BITS_PER_CH:  rsp_data <= `BITS_PER_CH_VALUE;
          `BYTE_CHAN_COUNT:   rsp_data <= `CHAN_COUNT_VALUE;
          `BYTE_GROUP_ERR:    rsp_data <= store_q;
          `BYTE_CH0_ERR:      rsp_data <= store_q;
          `BYTE_CH1_ERR:      rsp_data <= store_q;
          5'd16:              rsp_data <= store_q;
          5'd17:              rsp_data <= store_q;
          5'd18:              rsp_data <= store_q;
          5'd19:              rsp_data <= stamp_r[31:24];
          default:            rsp_data <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ---- diag_record_map.vh ----
// Constants for the diagnostic record and microsecond timer of the analog input module.
`ifndef DIAG_RECORD_MAP_VH
`define DIAG_RECORD_MAP_VH

// Timing.
`define CLOCK_FREQ_MHZ        100
`define US_TICK_PERIOD_NS     1000
`define CLOCK_PERIOD_NS       10
`define US_TICK_CYCLES        (`US_TICK_PERIOD_NS / `CLOCK_PERIOD_NS)

// Record access selectors.
`define RECNUM_SHORT          8'h00
`define RECNUM_FULL           8'h01
`define OBJIDX_SHORT          16'h2f00
`define OBJIDX_FULL           16'h2f01
`define OBJIDX_DIAG_BYTES     16'h5005
`define SUBIDX_FIRST_BYTE     8'h02
`define RECORD_LEN_FULL       5'd20
`define RECORD_LEN_SHORT      5'd4

// Byte positions within the record.
`define BYTE_MODULE_ERR       5'd0
`define BYTE_MODULE_CLASS     5'd1
`define BYTE_RESERVED_C       5'd2
`define BYTE_INTERNAL_ERR     5'd3
`define BYTE_CHAN_KIND        5'd4
`define BYTE_BITS_PER_CH      5'd5
`define BYTE_CHAN_COUNT       5'd6
`define BYTE_GROUP_ERR        5'd7
`define BYTE_CH0_ERR          5'd8
`define BYTE_CH1_ERR          5'd9
`define BYTE_TSTAMP0          5'd16

// Constant record contents and the diagnostic interrupt enable code.
`define MODULE_CLASS_VALUE    8'h15
`define CHAN_KIND_VALUE       8'h71
`define BITS_PER_CH_VALUE     8'h08
`define CHAN_COUNT_VALUE      8'h02
`define DIAG_ENABLE_ON        8'h40

// Field positions, module error byte.
`define MERR_MODULE_FAIL      0
`define MERR_INTERNAL         1
`define MERR_EXTERNAL         2
`define MERR_CHANNEL          3
`define MERR_AUX_SUPPLY       4
`define MERR_PARAM            7

// Field positions, internal error byte.
`define IERR_BUF_OVERFLOW     3
`define IERR_COMM             4
`define IERR_PIRQ_LOST        6

// Field positions, per-channel error byte.
`define CERR_CONFIG           0
`define CERR_PIRQ_LOST        5
`define CERR_UNDERFLOW        6
`define CERR_OVERFLOW         7

`endif

// ---- record_store.v ----
// Small byte store holding the captured variable part of the diagnostic record except the top timestamp byte.
`timescale 1ns/1ps
module record_store (
  input  wire       clock,
  input  wire       rst,
  input  wire       wr_en,
  input  wire [2:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire [2:0] rd_addr,
  output reg  [7:0] rd_data
);
  reg [7:0] mem [0:7];
  integer   i;

  // Write port clears on reset so the stored record bytes read zero before the first event.
  always @(posedge clock) begin
    if (rst) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem[i] <= 8'h00;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port.
  always @(posedge clock) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ---- coupler_model.sv ----
// Bus coupler model: sets the enable parameter byte and reads the diagnostic record.
`timescale 1ns/1ps
module coupler_model (
  input  wire        clock,
  output reg         req_valid,
  output reg  [1:0]  req_kind,
  output reg  [7:0]  record_number,
  output reg  [15:0] object_index,
  output reg  [7:0]  object_subindex,
  output reg  [4:0]  req_byte,
  output reg  [7:0]  diag_interrupt_enable,
  input  wire        rsp_valid,
  input  wire [7:0]  rsp_data,
  input  wire        rsp_error,
  input  wire        rsp_last
);
  // Bus idles with no request and the interrupt switched off.
  initial begin
    req_valid = 1'b0;
    {req_kind, record_number, object_index, object_subindex, req_byte} = 39'h0;
    diag_interrupt_enable = 8'h00;
  end

  // Only the two documented enable codes are ever written.
  task set_enable(input logic on);
    @(posedge clock);
    #1 diag_interrupt_enable = on ? 8'h40 : 8'h00;
  endtask

  // One read; selectors are inverted once taken, so a late sample by the block shows up.
  task read(input [1:0] k, input [15:0] sel, input [7:0] b, output [10:0] r);
    @(posedge clock);
    #1 req_valid = 1'b1;
    {req_kind, record_number, object_index, object_subindex, req_byte} = {k, sel[7:0], sel, b, b[4:0]};
    @(posedge clock);
    #1 req_valid = 1'b0;
    {req_kind, record_number, object_index, object_subindex, req_byte} =
      ~{req_kind, record_number, object_index, object_subindex, req_byte};
    @(posedge clock);
    #1 r = {rsp_valid, rsp_error, rsp_last, rsp_data};
  endtask
endmodule

// ---- analog_input_diag_record_asserts.sv ----
// Concurrent checks on the ports of the diagnostic record block.
`timescale 1ns/1ps
module diag_record_checker (
  input wire        clock,
  input wire        rst,
  input wire        req_valid,
  input wire [1:0]  req_kind,
  input wire [7:0]  record_number,
  input wire [15:0] object_index,
  input wire [7:0]  object_subindex,
  input wire [4:0]  req_byte,
  input wire        process_event,
  input wire        rsp_valid,
  input wire [7:0]  rsp_data,
  input wire        rsp_error,
  input wire        rsp_last,
  input wire        diag_incoming,
  input wire        diag_going,
  input wire        module_fault_led,
  input wire [15:0] process_irq_timestamp_low,
  input wire [31:0] us_timer
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_timer_step: assert property ($changed(us_timer) |-> us_timer == $past(us_timer) + 32'h1)
    else $error("timer moved by other than one");
  a_tick_period: assert property ($changed(us_timer) |-> ##100 $changed(us_timer))
    else $error("timer tick not one microsecond");
  a_rsp_latency: assert property (req_valid |-> ##2 rsp_valid)
    else $error("request not answered after two cycles");
  a_rsp_cause: assert property (rsp_valid |-> $past(req_valid, 2))
    else $error("answer without request");
  a_short_last: assert property (req_valid && req_kind == 2'd0 && record_number == 8'h00 && req_byte == 5'd3
    |-> ##2 rsp_last && !rsp_error) else $error("short record not four bytes");
  a_full_index: assert property (req_valid && req_kind == 2'd1 && object_index == 16'h2f01 && req_byte == 5'd19
    |-> ##2 rsp_last && !rsp_error) else $error("full index not twenty bytes");
  a_sub_low: assert property (req_valid && req_kind == 2'd2 && object_subindex < 8'h02
    |-> ##2 rsp_error && rsp_data == 8'h00) else $error("low subindex accepted");
  a_kind_code: assert property (req_valid && req_kind == 2'd0 && record_number == 8'h01 && req_byte == 5'd4
    |-> ##2 rsp_data == 8'h71) else $error("channel kind byte wrong");
  a_led_on: assert property ($rose(module_fault_led) |-> diag_incoming)
    else $error("fault light on without incoming event");
  a_going_clears: assert property (diag_going |-> !module_fault_led && $past(module_fault_led))
    else $error("going event without lit fault light");
  a_pirq_stamp: assert property (process_event |=> {16'h0, process_irq_timestamp_low} == ($past(us_timer) & 32'h0000ffff))
    else $error("process stamp not timer low half");

  // Main scenarios reached.
  c_incoming: cover property (diag_incoming);
  c_going: cover property (diag_going);
  c_refused: cover property (rsp_valid && rsp_error);
endmodule

bind analog_input_diag_record diag_record_checker i_chk (.clock(clock), .rst(rst), .req_valid(req_valid),
  .req_kind(req_kind), .record_number(record_number), .object_index(object_index),
  .object_subindex(object_subindex), .req_byte(req_byte), .process_event(process_event), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .rsp_error(rsp_error), .rsp_last(rsp_last), .diag_incoming(diag_incoming),
  .diag_going(diag_going), .module_fault_led(module_fault_led),
  .process_irq_timestamp_low(process_irq_timestamp_low), .us_timer(us_timer));

// ---- analog_input_diag_record_tb.sv ----
// Self-checking bench for the diagnostic record block against a byte model of the record.
`timescale 1ns/1ps
module analog_input_diag_record_tb;
  logic        clock, rst, pe, req_valid, rsp_valid, rsp_error, rsp_last, diag_incoming, diag_going, module_fault_led;
  logic [1:0]  req_kind;
  logic [4:0]  req_byte;
  logic [7:0]  record_number, object_subindex, diag_interrupt_enable, rsp_data;
  logic [7:0]  m [0:19];
  logic [10:0] r;
  logic [14:0] cz;
  logic [15:0] object_index, process_irq_timestamp_low;
  logic [31:0] us_timer, lfsr, t;
  integer      fails, check_count, cyc, i, k, e, n;

  analog_input_diag_record i_dut (.clock(clock), .rst(rst), .diag_interrupt_enable(diag_interrupt_enable),
    .cause_module_fail(cz[0]), .cause_internal(cz[1]), .cause_external(cz[2]), .cause_aux_supply(cz[3]),
    .cause_param(cz[4]), .cause_buf_overflow(cz[5]), .cause_comm(cz[6]), .cause_config(cz[8:7]),
    .cause_pirq_lost(cz[10:9]), .cause_underflow(cz[12:11]), .cause_overflow(cz[14:13]), .process_event(pe),
    .req_valid(req_valid), .req_kind(req_kind), .record_number(record_number), .object_index(object_index),
    .object_subindex(object_subindex), .req_byte(req_byte), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .rsp_last(rsp_last), .diag_incoming(diag_incoming), .diag_going(diag_going),
    .module_fault_led(module_fault_led), .process_irq_timestamp_low(process_irq_timestamp_low), .us_timer(us_timer));

  coupler_model i_bus (.clock(clock), .req_valid(req_valid), .req_kind(req_kind), .record_number(record_number),
    .object_index(object_index), .object_subindex(object_subindex), .req_byte(req_byte),
    .diag_interrupt_enable(diag_interrupt_enable), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .rsp_last(rsp_last));

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Cycles since reset release; the expected microsecond count is this over 100.
  always @(posedge clock) begin
    if (rst) cyc <= 0;
    else cyc <= cyc + 1;
  end

  function [31:0] lfsr_next(input [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Builds the expected record from the cause levels and the captured time.
  task snap(input [31:0] ts);
    for (k = 0; k < 20; k = k + 1) m[k] = 8'h00;
    m[0] = {cz[4], 2'b00, cz[3], |cz[14:7], cz[2:0]};
    m[1] = 8'h15;
    m[3] = {1'b0, |cz[10:9], 1'b0, cz[6], cz[5], 3'b000};
    m[4] = 8'h71;
    m[5] = 8'h08;
    m[6] = 8'h02;
    m[8] = {cz[13], cz[11], cz[9], 4'h0, cz[7]};
    m[9] = {cz[14], cz[12], cz[10], 4'h0, cz[8]};
    m[7] = {6'h00, |m[9], |m[8]};
    {m[19], m[18], m[17], m[16]} = ts;
  endtask

  // One read through the coupler, compared with the model.
  task rd(input [1:0] kd, input [15:0] sel, input integer b, input integer len);
    integer idx;
    idx = (kd == 2'd2) ? b - 2 : b;
    i_bus.read(kd, sel, b[7:0], r);
    check("valid", r[10], 1'b1);
    check("error", r[9], (idx < 0 || idx >= len));
    check("data", r[7:0], (idx < 0 || idx >= len) ? 8'h00 : m[idx]);
    if (idx >= 0 && idx < len) check("last", r[8], (kd == 2'd2) || idx == len - 1);
  endtask

  // Every byte by every access form, two past the top end, one below the first subindex, and unknown selectors.
  task sweep;
    for (i = 0; i < 22; i = i + 1) begin
      rd(2'd0, 16'h0001, i, 20);
      rd(2'd0, 16'h0000, i, 4);
      rd(2'd1, 16'h2f01, i, 20);
      rd(2'd1, 16'h2f00, i, 4);
      rd(2'd2, 16'h5005, i + 2, 20);
    end
    rd(2'd0, 16'h0002, 0, 0);
    rd(2'd1, 16'h2f02, 0, 0);
    rd(2'd2, 16'h5005, 1, 0);
  endtask

  // Counts edges until the chosen event pulse, giving up after 40.
  task wait_pulse(input logic going);
    n = 0;
    while ((going ? diag_going : diag_incoming) !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1 n = n + 1;
    end
  endtask

  // Moves to mid-microsecond, so the tick phase of the block cannot matter, and stamps a process event.
  task phase;
    while (cyc % 100 != 50) begin
      @(posedge clock);
      #1;
    end
    t = cyc / 100;
    check("timer", us_timer, t);
    pe = 1'b1;
    @(posedge clock);
    #1 pe = 1'b0;
    check("process stamp", process_irq_timestamp_low, {16'h0, t[15:0]});
  endtask

  // Event rounds: enabled, disabled, enabled again.
  initial begin
    rst = 1'b1;
    cz = 15'h0000;
    pe = 1'b0;
    fails = 0;
    check_count = 0;
    lfsr = 32'h45ee6087;
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    snap(32'h0);
    sweep;
    for (e = 0; e < 3; e = e + 1) begin
      i_bus.set_enable(e != 1);
      phase;
      lfsr = lfsr_next(lfsr);
      cz = lfsr[14:0] | 15'h0001;
      wait_pulse(1'b0);
      check("incoming", (e != 1) ? (n == 9) : (n == 40), 1'b1);
      check("led on", module_fault_led, e != 1);
      if (e != 1) snap(t);
      sweep;
      if (e != 1) begin
        lfsr = lfsr_next(lfsr);
        cz = lfsr[14:0] | 15'h0001;
        wait_pulse(1'b0);
        check("later incoming", n, 40);
        sweep;
      end
      cz = 15'h0000;
      wait_pulse(1'b1);
      check("going", (e != 1) ? (n <= 2) : (n == 40), 1'b1);
      check("led off", module_fault_led, 1'b0);
    end
    complete_run;
  end

  // Cuts a hang short well beyond the expected run of about 2400 cycles.
  initial begin
    #300000;
    fails = fails + 1;
    complete_run;
  end
endmodule
